// >>> verilog/mbs_pkg.sv
package mbs_pkg;
  // Matrix geometry.
  localparam int DRIVE_LINES = 8;
  localparam int RECV_LINES = 2;
  localparam int KEY_COUNT = 16;
  localparam int KEY_W = 4;
  // Clock rate and documented times.
  localparam int CLK_HZ = 40000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DWELL_MIN_NS = 250;
  localparam int SCAN_PERIOD_MS = 16;
  // Least dwell rounds up to whole cycles.
  localparam int DWELL_CYCLES = (DWELL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Scan period in cycles, rounded down.
  localparam int PERIOD_CYCLES = (CLK_HZ / 1000) * SCAN_PERIOD_MS;
  // Width of a burst length setting and of the conversion count.
  localparam int BURST_W = 8;
  localparam int COUNT_W = 16;
  // Limit on the ramp timer before a missing zero crossing is given up.
  localparam int RAMP_TIMEOUT = 65535;
  // Cycles the receive line is clamped before the ramp is timed.
  localparam int SETTLE_CYCLES = 4;
  // Sequencer states.
  typedef enum logic [2:0] {
    MBS_SLEEP = 3'b000,
    MBS_SELECT = 3'b001,
    MBS_HIGH = 3'b010,
    MBS_LOW = 3'b011,
    MBS_CLAMP = 3'b100,
    MBS_RAMP = 3'b101
  } mbs_state_t;
endpackage

// >>> verilog/mbs_period_timer.sv
`timescale 1ns/1ps
module mbs_period_timer
  import mbs_pkg::*;
#(
  parameter int PERIOD = PERIOD_CYCLES
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  output logic tick_o // One-cycle pulse at each period start.
);
  logic [31:0] count; // Cycles elapsed in the current period.
  logic [31:0] next_count; // Next value of the counter.
  logic next_tick; // Next value of the tick.

  // Counts the period and pulses once at its wrap.
  always_comb begin
    next_tick = 1'b0;
    if (count == 32'(PERIOD - 1)) begin
      next_count = 32'h0;
      next_tick = 1'b1;
    end else begin
      next_count = count + 32'h1;
    end
  end

  // Registers the counter; the first period starts right after reset.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count <= 32'(PERIOD - 1);
      tick_o <= 1'b0;
    end else begin
      count <= next_count;
      tick_o <= next_tick;
    end
  end
endmodule

// >>> verilog/mbs_scan_sequencer.sv
`timescale 1ns/1ps
module mbs_scan_sequencer
  import mbs_pkg::*;
#(
  parameter int PERIOD = PERIOD_CYCLES,
  parameter int DWELL = DWELL_CYCLES
) (
  input wire logic clk_i, // System clock, 40 MHz.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic [KEY_COUNT*BURST_W-1:0] pulse_count_setting_i, // Burst length per key.
  input wire logic zero_cross_i, // High once the ramped terminal crosses zero.
  output logic [DRIVE_LINES-1:0] drive_o, // Drive line levels.
  output logic [RECV_LINES-1:0] recv_clamp_o, // High clamps a receive line to ground.
  output logic [RECV_LINES-1:0] ramp_en_o, // High lets the resistor ramp a line.
  output logic [COUNT_W-1:0] count_o, // Conversion count of the last key.
  output logic [KEY_W-1:0] key_o, // Index of the key in count_o.
  output logic valid_o, // One-cycle strobe for a new count.
  output logic asleep_o // High while idle between periods.
);
  mbs_state_t state; // Sequencer state.
  mbs_state_t next_state; // Next state.
  logic [KEY_W-1:0] key; // Key under scan.
  logic [KEY_W-1:0] next_key; // Next key.
  logic [BURST_W-1:0] pulses; // Pulses left in the burst.
  logic [BURST_W-1:0] next_pulses; // Next pulse count.
  logic [COUNT_W-1:0] timer; // Dwell and ramp timer.
  logic [COUNT_W-1:0] next_timer; // Next timer.
  logic [DRIVE_LINES-1:0] next_drive; // Next drive outputs.
  logic [RECV_LINES-1:0] next_clamp; // Next clamp outputs.
  logic [RECV_LINES-1:0] next_ramp; // Next ramp enables.
  logic [COUNT_W-1:0] next_count; // Next count output.
  logic [KEY_W-1:0] next_key_o; // Next key output.
  logic next_valid; // Next strobe.
  logic next_asleep; // Next sleep flag.
  logic tick; // Period start pulse.
  logic at_last; // Key is the last index.

  // Returns the burst length of one key.
  function automatic logic [BURST_W-1:0] burst_of(input logic [KEY_W-1:0] k,
      input logic [KEY_COUNT*BURST_W-1:0] s);
    burst_of = s[k*BURST_W +: BURST_W];
  endfunction

  // Drive line of a key is its low three bits.
  function automatic logic [DRIVE_LINES-1:0] drive_of(input logic [KEY_W-1:0] k);
    drive_of = DRIVE_LINES'(1) << k[2:0];
  endfunction

  // Receive line of a key is its top bit.
  function automatic logic [RECV_LINES-1:0] recv_of(input logic [KEY_W-1:0] k);
    recv_of = RECV_LINES'(1) << k[3];
  endfunction

  // Period timer that restarts the scan.
  mbs_period_timer #(
    .PERIOD(PERIOD)
  ) u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_o(tick)
  );

  // The last index ends a scan whether or not that key is enabled.
  assign at_last = (key == KEY_W'(KEY_COUNT - 1));

  // Computes the next state of the scan and of every output.
  always_comb begin
    // Defaults: drive low, all receive lines clamped, no ramp, results held.
    next_state = state;
    next_key = key;
    next_pulses = pulses;
    next_timer = timer;
    next_drive = '0;
    next_clamp = {RECV_LINES{1'b1}};
    next_ramp = '0;
    next_count = count_o;
    next_key_o = key_o;
    next_valid = 1'b0;
    next_asleep = 1'b0;
    case (state)
      MBS_SLEEP: begin
        // All lines stay idle, receive lines held clamped.
        next_asleep = 1'b1;
        if (tick) begin
          // A new period starts the scan again at key 0.
          next_state = MBS_SELECT;
          next_key = '0;
          next_asleep = 1'b0;
        end
      end
      MBS_SELECT: begin
        // Disabled keys are passed over at one cycle each.
        if (burst_of(key, pulse_count_setting_i) != '0) begin
          // Enabled key: load its burst and open its receive line.
          next_pulses = burst_of(key, pulse_count_setting_i);
          next_timer = '0;
          next_state = MBS_HIGH;
          next_drive = drive_of(key);
          next_clamp = ~recv_of(key);
        end else if (at_last) begin
          // Disabled last key: the scan is over.
          next_state = MBS_SLEEP;
          next_asleep = 1'b1;
        end else begin
          // Disabled key: step on at once without driving anything.
          next_key = key + KEY_W'(1);
        end
      end
      MBS_HIGH: begin
        // Drive high, receive open: charge flows into the sample capacitor.
        next_drive = drive_of(key);
        next_clamp = ~recv_of(key);
        next_timer = timer + COUNT_W'(1);
        if (timer >= COUNT_W'(DWELL - 1)) begin
          // Dwell spent: drop the drive and clamp on its falling edge.
          next_timer = '0;
          next_state = MBS_LOW;
          next_drive = '0;
          next_clamp = {RECV_LINES{1'b1}};
        end
      end
      MBS_LOW: begin
        // Drive low with the receive line clamped to neutralise charge.
        next_timer = timer + COUNT_W'(1);
        if (timer >= COUNT_W'(DWELL - 1)) begin
          next_timer = '0;
          if (pulses == BURST_W'(1)) begin
            // Last pulse done: clamp before the ramp is timed.
            next_state = MBS_CLAMP;
          end else begin
            // More pulses to go: raise the drive again.
            next_pulses = pulses - BURST_W'(1);
            next_state = MBS_HIGH;
            next_drive = drive_of(key);
            next_clamp = ~recv_of(key);
          end
        end
      end
      MBS_CLAMP: begin
        // Clamp after the burst so the far terminal swings negative.
        next_timer = timer + COUNT_W'(1);
        if (timer >= COUNT_W'(SETTLE_CYCLES - 1)) begin
          // Settle spent: the ramp starts on the active line.
          next_timer = '0;
          next_state = MBS_RAMP;
          next_ramp = recv_of(key);
        end
      end
      MBS_RAMP: begin
        // Time the resistor ramp until the zero crossing is seen.
        next_ramp = recv_of(key);
        next_timer = timer + COUNT_W'(1);
        if (zero_cross_i || timer == COUNT_W'(RAMP_TIMEOUT)) begin
          // A timed-out ramp still reports, so the scan never stalls.
          next_count = timer;
          next_key_o = key;
          next_valid = 1'b1;
          next_ramp = '0;
          next_timer = '0;
          if (at_last) begin
            // Last key done: sleep until the next period.
            next_state = MBS_SLEEP;
            next_asleep = 1'b1;
          end else begin
            // More keys remain: select the next one.
            next_key = key + KEY_W'(1);
            next_state = MBS_SELECT;
          end
        end
      end
      default: begin
        // Unused state codes fall back to sleep.
        next_state = MBS_SLEEP;
        next_asleep = 1'b1;
      end
    endcase
  end

  // Registers sequencer state and all outputs.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      // Reset leaves every line idle and the device asleep.
      state <= MBS_SLEEP;
      key <= '0;
      pulses <= '0;
      timer <= '0;
      drive_o <= '0;
      recv_clamp_o <= {RECV_LINES{1'b1}};
      ramp_en_o <= '0;
      count_o <= '0;
      key_o <= '0;
      valid_o <= 1'b0;
      asleep_o <= 1'b1;
    end else begin
      // Every output is a register, so no pin sees a decode glitch.
      state <= next_state;
      key <= next_key;
      pulses <= next_pulses;
      timer <= next_timer;
      drive_o <= next_drive;
      recv_clamp_o <= next_clamp;
      ramp_en_o <= next_ramp;
      count_o <= next_count;
      key_o <= next_key_o;
      valid_o <= next_valid;
      asleep_o <= next_asleep;
    end
  end
endmodule

// >>> bench/mbs_scan_sequencer_monitor.sv
`timescale 1ns/1ps
// Watches the sequencer pins for dwell, clamp, ramp and idle faults.
module mbs_scan_sequencer_monitor
  import mbs_pkg::*;
#(
  parameter int PERIOD = PERIOD_CYCLES, // Scan period in cycles.
  parameter int DWELL = DWELL_CYCLES // Drive phase length in cycles.
) (
  input wire logic clk_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic [KEY_COUNT*BURST_W-1:0] pulse_count_setting_i, // Settings.
  input wire logic zero_cross_i, // Comparator level.
  input wire logic [DRIVE_LINES-1:0] drive_o, // Drive lines.
  input wire logic [RECV_LINES-1:0] recv_clamp_o, // Clamps.
  input wire logic [RECV_LINES-1:0] ramp_en_o, // Ramp enables.
  input wire logic [COUNT_W-1:0] count_o, // Count.
  input wire logic [KEY_W-1:0] key_o, // Key index.
  input wire logic valid_o, // Strobe.
  input wire logic asleep_o // Idle flag.
);
  int hi_cnt; // Cycles the drive has been high so far.
  int next_hi_cnt; // Next value of hi_cnt.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Counts high-phase cycles so that the dwell length can be checked.
  always_comb begin
    next_hi_cnt = (|drive_o) ? hi_cnt + 1 : 0;
  end
  // Registers the counter; reset clears it.
  always_ff @(posedge clk_i) begin
    hi_cnt <= rst_n_i ? next_hi_cnt : 0;
  end
  property p_one_line; $onehot0(drive_o); endproperty
  a_one_line: assert property (p_one_line) else $error("two drive lines high");
  property p_dwell; $fell(|drive_o) |-> hi_cnt == DWELL && hi_cnt >= DWELL_CYCLES; endproperty
  a_dwell: assert property (p_dwell) else $error("drive high phase wrong length");
  property p_capture; |drive_o |-> $countones(recv_clamp_o) == 1; endproperty
  a_capture: assert property (p_capture) else $error("clamp wrong while driving");
  property p_fall_clamp; $fell(|drive_o) |-> recv_clamp_o == 2'h3; endproperty
  a_fall_clamp: assert property (p_fall_clamp) else $error("no clamp on fall");
  property p_idle; asleep_o |-> drive_o == 8'h00 && recv_clamp_o == 2'h3 && !ramp_en_o; endproperty
  a_idle: assert property (p_idle) else $error("lines active in sleep");
  property p_strobe; valid_o |=> !valid_o; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe longer than one cycle");
  property p_ramp_end; $fell(|ramp_en_o) |-> valid_o; endproperty
  a_ramp_end: assert property (p_ramp_end) else $error("ramp ended without count");
  property p_ramp_start; $rose(|ramp_en_o) |-> $past(recv_clamp_o, 4) == 2'h3; endproperty
  a_ramp_start: assert property (p_ramp_start) else $error("ramp without clamp");
  property p_apart; |drive_o |-> ramp_en_o == 2'h0 && !asleep_o; endproperty
  a_apart: assert property (p_apart) else $error("ramp during burst");
  property p_hold; !valid_o |-> $stable(key_o) && $stable(count_o); endproperty
  a_hold: assert property (p_hold) else $error("result changed without strobe");
endmodule
bind mbs_scan_sequencer mbs_scan_sequencer_monitor #(.PERIOD(PERIOD), .DWELL(DWELL))
  mbs_scan_sequencer_monitor_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .pulse_count_setting_i(pulse_count_setting_i), .zero_cross_i(zero_cross_i),
  .drive_o(drive_o), .recv_clamp_o(recv_clamp_o), .ramp_en_o(ramp_en_o),
  .count_o(count_o), .key_o(key_o), .valid_o(valid_o), .asleep_o(asleep_o));

// >>> bench/mbs_matrix_model.sv
`timescale 1ns/1ps
// Electrode matrix: the ramp crosses zero a fixed time after it starts.
module mbs_matrix_model #(
  parameter int BASE = 5 // Ramp cycles on receive line 0; line 1 takes 3 more.
) (
  input wire logic clk_i, // System clock.
  input wire logic [1:0] ramp_en_i, // Ramp enables from the sequencer.
  output logic zero_cross_o // Comparator level.
);
  int cnt = 0; // Ramp cycles seen so far.
  logic tgl = 1'b0; // Idle pattern, so a stale level is never seen.
  // Counts ramp cycles and flips the idle pattern every cycle.
  always @(posedge clk_i) begin
    cnt <= (|ramp_en_i) ? cnt + 1 : 0;
    tgl <= ~tgl;
  end
  // Outside a ramp the comparator output means nothing and keeps changing.
  assign zero_cross_o = (|ramp_en_i) ? (cnt >= BASE + 3 * ramp_en_i[1]) : tgl;
endmodule

// >>> bench/mbs_scan_sequencer_tb_top.sv
`timescale 1ns/1ps
// Random burst settings for the first two periods; each result is checked against a key list.
module mbs_scan_sequencer_tb_top;
  import mbs_pkg::*;
  logic clk_i = 1'b0; // Clock.
  logic rst_n_i = 1'b0; // Reset.
  logic [KEY_COUNT*BURST_W-1:0] set = '0; // Burst settings.
  logic zc; // Comparator level from the matrix.
  logic [7:0] drv; // Drive lines.
  logic [1:0] ramp; // Ramp enables.
  logic [15:0] cnt; // Count.
  logic [3:0] key; // Key index.
  logic vld; // Strobe.
  logic slp; // Idle flag.
  int miscompares = 0; // Mismatches.
  int n_checks = 0; // Comparisons.
  int seed = 86997; // Random seed.
  int pulses = 0; // Drive pulses since the last result.
  int dline = 0; // Drive line of the last pulse.
  int len[16]; // Burst lengths set this period.
  always #12.5 clk_i = ~clk_i;
  mbs_scan_sequencer #(.PERIOD(2000), .DWELL(10)) mbs_scan_sequencer_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .pulse_count_setting_i(set), .zero_cross_i(zc), .drive_o(drv),
    .recv_clamp_o(), .ramp_en_o(ramp), .count_o(cnt), .key_o(key), .valid_o(vld),
    .asleep_o(slp));
  mbs_matrix_model mbs_matrix_model_i (.clk_i(clk_i), .ramp_en_i(ramp), .zero_cross_o(zc));
  // Counts pulses and notes which line carried them.
  always @(drv) begin
    if (drv != 8'h00) begin
      pulses++;
      dline = $clog2(drv);
    end
  end
  // Compares one result and reports a mismatch.
  task automatic check(input logic ok);
    n_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t mismatch at key %0d", $time, key);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Waits a bounded time for a strobe, or for sleep when want_sleep is set.
  task automatic wait_for(input bit want_sleep);
    int i;
    for (i = 0; i < 8000; i++) begin
      @(posedge clk_i);
      #2;
      if ((want_sleep ? slp : vld) === 1'b1) return;
    end
    miscompares++;
    tally_and_finish();
  endtask
  // Four periods: two random, one with only the end keys, one all disabled.
  initial begin
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 16; k++) begin
        len[k] = (r < 2) ? ($random(seed) & 3) : ((r == 2 && k % 15 == 0) ? 255 : 0);
        set[8*k +: 8] = len[k][7:0];
      end
      if (r == 0) begin
        repeat (4) @(posedge clk_i);
        #2 rst_n_i = 1'b1;
      end
      pulses = 0;
      for (int k = 0; k < 16; k++) begin
        if (len[k] != 0) begin
          wait_for(1'b0);
          check(key === 4'(k));
          check(cnt === 16'(5 + 3 * (k / 8)));
          check(pulses == len[k]);
          check(dline == k % 8);
          pulses = 0;
        end
      end
      wait_for(1'b1);
      check(slp === 1'b1);
    end
    repeat (2500) @(posedge clk_i);
    check(pulses == 0);
    tally_and_finish();
  end
endmodule
